// ---- hw/dtp_positioner.sv ----
// Destination table positioner: APB registers, start handling and speed profile.
// Assumes clean synchronous digital inputs and an actual position sampled on clk_sys.
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// R1 - Holds sixteen selectable destination records, each with target and profile.
// R2 - Holds one extra record for moves commanded over the serial port.
// R3 - Each record gives the speed the drive has on arrival.
// R4 - Nonzero final speed keeps the drive moving after arrival.
// R5 - Separate acceleration and deceleration ramp times per record.
// R6 - Zero smoothing gives linear ramps, nonzero a parabola-shaped speed.
// R7 - Smoothing equal to ramp time gives a sine-like acceleration.
// R8 - Absolute mode measures the target from the homed reference point.
// R9 - Relative-to-last mode adds the value to the last destination.
// R10 - Relative mode adds the value to the measured actual position.
// R11 - Wait policy latches a mid-move start and runs it afterwards.
// R12 - Interrupt policy aborts the move and heads to the new target.
// R13 - Ignore policy discards a start that arrives mid-move.
// R14 - Per-record feed-forward gain, zero by default, scales speed.
// R15 - The controller supplies a bounce-free start strobe.
// R16 - A rising start edge latches the selection and begins the move.
// R17 - Four select inputs form index 0 to 15, bit 3 most significant.
// R18 - Select inputs are sampled only on the start edge.
module dtp_positioner #(
	parameter int MS_CYCLES = dtp_pkg::MS_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// APB slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// Digital inputs from the higher-order controller
	input wire logic [3:0] destinationSelect,
	input wire logic startStrobe,
	// Position feedback
	input wire logic signed [31:0] actualPos,
	// Setpoints to the drive loops
	output logic signed [31:0] posSetpoint,
	output logic signed [16:0] velSetpoint,
	output logic signed [31:0] feedForward,
	output logic moveActive,
	output logic destReached
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic enable;
		logic signed [31:0] homePos;
		logic [4:0] recSel;
		logic [31:0] rdData;
		logic rdErr;
		logic startPrev;
		dtp_pkg::dtp_phase_t phase;
		dtp_pkg::dtp_ramp_t rampKind;
		dtp_pkg::dtp_rec_t rec;
		logic [4:0] activeIdx;
		logic signed [31:0] dest;
		logic signed [31:0] posCmd;
		logic dirNeg;
		logic [15:0] vMag;
		logic [15:0] v0;
		logic [15:0] vGoal;
		logic [15:0] rampTime;
		logic [15:0] rampPhase;
		logic [15:0] msCnt;
		logic pending;
		logic [4:0] pendingIdx;
		logic reached;
		logic signed [31:0] ffOut;
	} dtp_core_state_t;

	dtp_core_state_t s;
	dtp_core_state_t n;

	dtp_pkg::dtp_rec_t recA, recB, recC, wrRec, lRec;
	logic wrEn, setup, access, wrHit, rdErrMux, busy, msTick, startEdge, serialReq, req, launch, fromPending;
	logic [4:0] reqIdx;
	logic [31:0] rdMux, wdata, status;
	logic phaseStart, weightStart;
	logic [15:0] phaseNum, weightNum, weightDen, rampPhaseNext;
	logic [10:0] qPhase, wSmooth;
	logic [21:0] q2Full, q3Full, blendA, blendB;
	logic [10:0] q2, q3, blend;
	logic [12:0] sShape;
	logic [22:0] blendSum;
	logic signed [16:0] vDiff, vShapedWide;
	logic signed [28:0] vProd;
	logic [15:0] vShaped;
	logic signed [32:0] remW, velProd;
	logic [32:0] absRem, brakeDist;
	logic toward, newDir;
	logic signed [31:0] stepS, newDest;
	logic signed [16:0] velS;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	dtp_frac_div phaseDiv (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.start(phaseStart),
		.num(phaseNum),
		.den(s.rampTime),
		.quot(qPhase)
	);

	dtp_frac_div weightDiv (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.start(weightStart),
		.num(weightNum),
		.den(weightDen),
		.quot(wSmooth)
	);

	dtp_record_store store (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.wrEn(wrEn),
		.wrIdx(s.recSel),
		.wrRec(wrRec),
		.rdIdxA(s.recSel),
		.rdIdxB(reqIdx),
		.rdIdxC(s.pendingIdx),
		.recA(recA),
		.recB(recB),
		.recC(recC)
	);

	// ****************************************************************
	// Register read decode and profile arithmetic
	// ****************************************************************
	always_comb begin
		status = '0;
		status[dtp_pkg::STAT_BUSY_BIT] = busy;
		status[dtp_pkg::STAT_PENDING_BIT] = s.pending;
		status[dtp_pkg::STAT_REACHED_BIT] = s.reached;
		status[dtp_pkg::STAT_IDX_LSB +: 5] = s.activeIdx;
		rdErrMux = 1'b0;
		case (paddr)
			dtp_pkg::REG_CONTROL: rdMux = {31'h00000000, s.enable};
			dtp_pkg::REG_STATUS: rdMux = status;
			dtp_pkg::REG_REC_SELECT: rdMux = {27'h0000000, s.recSel};
			dtp_pkg::REG_REC_TARGET: rdMux = recA.target;
			dtp_pkg::REG_REC_SPEED: rdMux = {16'h0000, recA.speed};
			dtp_pkg::REG_REC_FINAL: rdMux = {16'h0000, recA.finalSpeed};
			dtp_pkg::REG_REC_ACCEL: rdMux = {16'h0000, recA.accelTime};
			dtp_pkg::REG_REC_DECEL: rdMux = {16'h0000, recA.decelTime};
			dtp_pkg::REG_REC_SMOOTH: rdMux = {16'h0000, recA.smoothTime};
			dtp_pkg::REG_REC_MODE: rdMux = {26'h0000000, recA.policy, 2'h0, recA.mode};
			dtp_pkg::REG_REC_FFGAIN: rdMux = {16'h0000, recA.ffGain};
			dtp_pkg::REG_ACT_POS: rdMux = actualPos;
			dtp_pkg::REG_CMD_POS: rdMux = s.posCmd;
			dtp_pkg::REG_CMD_VEL: rdMux = {{15{velS[16]}}, velS};
			dtp_pkg::REG_DEST_POS: rdMux = s.dest;
			default: begin
				rdMux = 32'h00000000;
				rdErrMux = 1'b1;
			end
		endcase
		for (int b = 0; b < 4; b++) begin
			wdata[b*8 +: 8] = pstrb[b] ? pwdata[b*8 +: 8] : rdMux[b*8 +: 8];
		end
		// Blend of linear fraction and a smoothstep, weighted by smoothing over ramp time.
		q2Full = qPhase * qPhase;
		q2 = q2Full[20:10];
		q3Full = q2 * qPhase;
		q3 = q3Full[20:10];
		sShape = {2'b00, q2} + {1'b0, q2, 1'b0} - {1'b0, q3, 1'b0}; // R7
		blendA = (dtp_pkg::FRAC_ONE - wSmooth) * qPhase;
		blendB = wSmooth * sShape[10:0];
		blendSum = {1'b0, blendA} + {1'b0, blendB}; // R6
		blend = blendSum[20:10];
		vDiff = $signed({1'b0, s.vGoal}) - $signed({1'b0, s.v0});
		vProd = vDiff * $signed({1'b0, blend});
		vShapedWide = $signed({1'b0, s.v0}) + vProd[26:10];
		vShaped = vShapedWide[15:0];
		velS = s.dirNeg ? -$signed({1'b0, s.vMag}) : $signed({1'b0, s.vMag});
		velProd = velS * s.rec.ffGain;
		stepS = {{15{velS[16]}}, velS};
		remW = {s.dest[31], s.dest} - {s.posCmd[31], s.posCmd};
		absRem = remW[32] ? 33'(-remW) : 33'(remW);
		toward = s.dirNeg ? (remW <= 0) : (remW >= 0);
		brakeDist = ((33'(s.vMag) + 33'(s.rec.finalSpeed)) * 33'(s.rec.decelTime)) >> 1;
	end

	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign wrHit = access & pwrite;
	assign busy = (s.phase == dtp_pkg::PH_RAMP) || (s.phase == dtp_pkg::PH_CRUISE);
	assign msTick = (s.msCnt == 16'(MS_CYCLES - 1));
	assign startEdge = startStrobe & ~s.startPrev; // R15 R16
	assign serialReq = wrHit && (paddr == dtp_pkg::REG_CONTROL) && wdata[dtp_pkg::CTRL_SERIAL_START_BIT];
	assign req = s.enable && (startEdge || serialReq);
	assign reqIdx = startEdge ? {1'b0, destinationSelect} : dtp_pkg::SERIAL_IDX; // R17 R18 R2
	assign fromPending = s.enable && s.pending && !busy;
	assign lRec = fromPending ? recC : recB;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		n = s;
		wrEn = 1'b0;
		wrRec = recA;
		launch = 1'b0;
		newDest = s.dest;
		newDir = 1'b0;
		phaseStart = 1'b0;
		phaseNum = 16'h0000;
		weightStart = 1'b0;
		weightNum = s.rec.smoothTime;
		weightDen = s.rec.accelTime;
		rampPhaseNext = s.rampPhase + 16'h0001;
		n.startPrev = startStrobe;
		n.msCnt = msTick ? 16'h0000 : s.msCnt + 16'h0001;
		n.ffOut = 32'(velProd >>> dtp_pkg::FF_SHIFT); // R14
		if (setup) begin
			n.rdData = rdMux;
			n.rdErr = rdErrMux;
		end
		// Register writes.
		if (wrHit && !rdErrMux) begin
			case (paddr)
				dtp_pkg::REG_CONTROL: begin
					n.enable = wdata[dtp_pkg::CTRL_ENABLE_BIT];
					if (wdata[dtp_pkg::CTRL_SET_HOME_BIT]) begin
						n.homePos = actualPos;
						n.posCmd = actualPos;
						n.dest = actualPos;
						n.vMag = 16'h0000;
						n.phase = dtp_pkg::PH_IDLE;
					end
				end
				dtp_pkg::REG_REC_SELECT: n.recSel = (wdata[4:0] <= dtp_pkg::SERIAL_IDX) ? wdata[4:0] : s.recSel;
				dtp_pkg::REG_REC_TARGET: wrRec.target = wdata;
				dtp_pkg::REG_REC_SPEED: wrRec.speed = wdata[15:0];
				dtp_pkg::REG_REC_FINAL: wrRec.finalSpeed = wdata[15:0];
				dtp_pkg::REG_REC_ACCEL: wrRec.accelTime = wdata[15:0];
				dtp_pkg::REG_REC_DECEL: wrRec.decelTime = wdata[15:0];
				dtp_pkg::REG_REC_SMOOTH: wrRec.smoothTime = wdata[15:0];
				dtp_pkg::REG_REC_MODE: begin
					wrRec.mode = dtp_pkg::dtp_mode_t'(wdata[dtp_pkg::MODE_LSB +: 2]);
					wrRec.policy = dtp_pkg::dtp_policy_t'(wdata[dtp_pkg::POLICY_LSB +: 2]);
				end
				dtp_pkg::REG_REC_FFGAIN: wrRec.ffGain = wdata[15:0];
				default: ;
			endcase
			wrEn = (paddr >= dtp_pkg::REG_REC_TARGET) && (paddr <= dtp_pkg::REG_REC_FFGAIN);
		end
		// Profile and position integration once per millisecond.
		if (msTick && (s.phase != dtp_pkg::PH_IDLE)) begin
			if (s.phase == dtp_pkg::PH_RAMP) begin
				if (rampPhaseNext >= s.rampTime) begin
					n.vMag = s.vGoal;
					n.phase = dtp_pkg::PH_CRUISE;
					if (s.rampKind == dtp_pkg::RK_BRAKE) begin
						// Reversal: the brake ramp has reached standstill, now accelerate the other way.
						n.dirNeg = ~s.dirNeg;
						n.phase = dtp_pkg::PH_RAMP;
						n.rampKind = dtp_pkg::RK_ACCEL;
						n.v0 = s.vGoal;
						n.vGoal = s.rec.speed;
						n.rampTime = s.rec.accelTime; // R5
						n.rampPhase = 16'h0000;
						phaseStart = 1'b1;
						weightStart = 1'b1;
					end
				end else begin
					n.vMag = vShaped; // R6
					n.rampPhase = rampPhaseNext;
					phaseStart = 1'b1;
					phaseNum = rampPhaseNext;
				end
			end
			if (s.phase == dtp_pkg::PH_ARRIVED) begin
				n.posCmd = s.posCmd + stepS; // R4
			end else if (toward && (absRem <= {17'h00000, s.vMag}) && (s.rampKind != dtp_pkg::RK_BRAKE)) begin
				n.posCmd = s.dest;
				n.reached = 1'b1;
				n.vMag = s.rec.finalSpeed; // R3
				n.phase = (s.rec.finalSpeed == 16'h0000) ? dtp_pkg::PH_IDLE : dtp_pkg::PH_ARRIVED; // R4
			end else begin
				n.posCmd = s.posCmd + stepS;
				if (toward && (s.rampKind == dtp_pkg::RK_ACCEL) && (s.rec.decelTime != 16'h0000)
						&& (s.vMag > s.rec.finalSpeed) && (absRem <= brakeDist + {17'h00000, s.vMag})) begin
					n.phase = dtp_pkg::PH_RAMP;
					n.rampKind = dtp_pkg::RK_DECEL;
					n.v0 = s.vMag;
					n.vGoal = s.rec.finalSpeed;
					n.rampTime = s.rec.decelTime; // R5
					n.rampPhase = 16'h0000;
					phaseStart = 1'b1;
					weightStart = 1'b1;
					weightDen = s.rec.decelTime;
				end
			end
		end
		if (weightStart && (n.rampKind == dtp_pkg::RK_ACCEL)) begin
			weightDen = s.rec.accelTime;
		end
		// Start handling: a latched start goes first once the running move has ended.
		if (fromPending) begin
			launch = 1'b1;
			n.pending = req; // R11
			n.pendingIdx = reqIdx;
		end else if (req) begin
			if (!busy) begin
				launch = 1'b1;
			end else begin
				case (recB.policy)
					dtp_pkg::POL_WAIT: begin
						n.pending = 1'b1; // R11
						n.pendingIdx = reqIdx;
					end
					dtp_pkg::POL_INTERRUPT: launch = 1'b1; // R12
					default: ; // R13
				endcase
			end
		end
		if (launch) begin
			case (lRec.mode)
				dtp_pkg::MODE_ABSOLUTE: newDest = s.homePos + lRec.target; // R8
				dtp_pkg::MODE_REL_LAST: newDest = s.dest + lRec.target; // R9
				default: newDest = actualPos + lRec.target; // R10
			endcase
			newDir = (newDest < n.posCmd);
			n.rec = lRec;
			n.activeIdx = fromPending ? s.pendingIdx : reqIdx;
			n.dest = newDest;
			n.reached = 1'b0;
			n.phase = dtp_pkg::PH_RAMP;
			n.rampPhase = 16'h0000;
			n.v0 = n.vMag;
			phaseStart = 1'b1;
			phaseNum = 16'h0000;
			weightStart = 1'b1;
			weightNum = lRec.smoothTime;
			// Turning round at speed would jerk the axis, so brake to standstill first.
			if ((n.vMag != 16'h0000) && (newDir != n.dirNeg)) begin
				n.rampKind = dtp_pkg::RK_BRAKE;
				n.vGoal = 16'h0000;
				n.rampTime = lRec.decelTime; // R5
				weightDen = lRec.decelTime;
			end else begin
				n.dirNeg = newDir;
				n.rampKind = dtp_pkg::RK_ACCEL;
				n.vGoal = lRec.speed;
				n.rampTime = lRec.accelTime; // R5
				weightDen = lRec.accelTime;
			end
		end
		if (!s.enable) begin
			n.phase = dtp_pkg::PH_IDLE;
			n.vMag = 16'h0000;
			n.pending = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign pready = 1'b1;
	assign prdata = s.rdData;
	assign pslverr = s.rdErr;
	assign posSetpoint = s.posCmd;
	assign velSetpoint = velS;
	assign feedForward = s.ffOut;
	assign moveActive = busy;
	assign destReached = s.reached;

endmodule : dtp_positioner
`default_nettype wire

// ---- common/dtp_pkg.sv ----
// Shared constants and types of the destination table positioner.
// Assumes one system clock at 10 MHz and a 1 ms profile tick derived from it.
package dtp_pkg;

	// ****************************************************************
	// Sizes
	// ****************************************************************
	localparam int POS_W = 32;
	localparam int SPD_W = 16;
	localparam int IDX_W = 5;
	localparam int NUM_TABLE = 16;
	localparam int NUM_REC = 17;
	localparam logic [IDX_W-1:0] SERIAL_IDX = 5'h10;
	localparam logic [10:0] FRAC_ONE = 11'h400;
	localparam logic [3:0] FRAC_STEPS = 4'hA;
	localparam int FF_SHIFT = 8;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 100;
	localparam int PROFILE_TICK_NS = 1000000;
	localparam int MS_CYCLES = PROFILE_TICK_NS / CLK_PERIOD_NS;

	// ****************************************************************
	// Register map, byte addresses
	// ****************************************************************
	localparam logic [7:0] REG_CONTROL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_REC_SELECT = 8'h08;
	localparam logic [7:0] REG_REC_TARGET = 8'h0C;
	localparam logic [7:0] REG_REC_SPEED = 8'h10;
	localparam logic [7:0] REG_REC_FINAL = 8'h14;
	localparam logic [7:0] REG_REC_ACCEL = 8'h18;
	localparam logic [7:0] REG_REC_DECEL = 8'h1C;
	localparam logic [7:0] REG_REC_SMOOTH = 8'h20;
	localparam logic [7:0] REG_REC_MODE = 8'h24;
	localparam logic [7:0] REG_REC_FFGAIN = 8'h28;
	localparam logic [7:0] REG_ACT_POS = 8'h2C;
	localparam logic [7:0] REG_CMD_POS = 8'h30;
	localparam logic [7:0] REG_CMD_VEL = 8'h34;
	localparam logic [7:0] REG_DEST_POS = 8'h38;

	// ****************************************************************
	// Field positions and reset values
	// ****************************************************************
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_SERIAL_START_BIT = 1;
	localparam int CTRL_SET_HOME_BIT = 2;
	localparam logic CTRL_ENABLE_RESET = 1'b0;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_PENDING_BIT = 1;
	localparam int STAT_REACHED_BIT = 2;
	localparam int STAT_IDX_LSB = 8;
	localparam int MODE_LSB = 0;
	localparam int POLICY_LSB = 4;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {MODE_REL_ACTUAL, MODE_REL_LAST, MODE_ABSOLUTE} dtp_mode_t;
	typedef enum logic [1:0] {POL_WAIT, POL_INTERRUPT, POL_IGNORE} dtp_policy_t;
	typedef enum logic [1:0] {PH_IDLE, PH_RAMP, PH_CRUISE, PH_ARRIVED} dtp_phase_t;
	typedef enum logic [1:0] {RK_ACCEL, RK_DECEL, RK_BRAKE} dtp_ramp_t;

	typedef struct packed {
		logic signed [POS_W-1:0] target;
		logic [SPD_W-1:0] speed;
		logic [SPD_W-1:0] finalSpeed;
		logic [15:0] accelTime;
		logic [15:0] decelTime;
		logic [15:0] smoothTime;
		logic signed [15:0] ffGain;
		dtp_mode_t mode;
		dtp_policy_t policy;
	} dtp_rec_t;

endpackage : dtp_pkg

// ---- hw/dtp_frac_div.sv ----
// Sequential fraction divider: result = min(num, den) * 1024 / den.
// Assumes start pulses are at least eleven cycles apart; the result holds between runs.
`timescale 1ns/10ps
`default_nettype none
module dtp_frac_div (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Request
	input wire logic start,
	input wire logic [15:0] num,
	input wire logic [15:0] den,
	// Result
	output logic [10:0] quot
);

	typedef struct packed {
		logic [16:0] rem;
		logic [15:0] den;
		logic [10:0] work;
		logic [3:0] cnt;
		logic [10:0] res;
	} dtp_div_state_t;

	dtp_div_state_t s;
	dtp_div_state_t n;
	logic [16:0] shifted;

	always_comb begin
		n = s;
		shifted = {s.rem[15:0], 1'b0};
		if (start) begin
			// A zero or smaller denominator means the ramp is already complete.
			if (num >= den) begin
				n.res = dtp_pkg::FRAC_ONE;
				n.cnt = 4'h0;
			end else begin
				n.rem = {1'b0, num};
				n.den = den;
				n.work = 11'h000;
				n.cnt = dtp_pkg::FRAC_STEPS;
			end
		end else if (s.cnt != 4'h0) begin
			if (shifted >= {1'b0, s.den}) begin
				n.rem = shifted - {1'b0, s.den};
				n.work = {s.work[9:0], 1'b1};
			end else begin
				n.rem = shifted;
				n.work = {s.work[9:0], 1'b0};
			end
			n.cnt = s.cnt - 4'h1;
			if (s.cnt == 4'h1) begin
				n.res = n.work;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign quot = s.res;

endmodule : dtp_frac_div
`default_nettype wire

// ---- hw/dtp_record_store.sv ----
// Destination record storage: sixteen table entries and one serial-port entry.
// One write port and three combinational read ports, all indexed by record number.
`timescale 1ns/10ps
`default_nettype none
module dtp_record_store (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Write port
	input wire logic wrEn,
	input wire logic [4:0] wrIdx,
	input wire dtp_pkg::dtp_rec_t wrRec,
	// Read ports
	input wire logic [4:0] rdIdxA,
	input wire logic [4:0] rdIdxB,
	input wire logic [4:0] rdIdxC,
	output dtp_pkg::dtp_rec_t recA,
	output dtp_pkg::dtp_rec_t recB,
	output dtp_pkg::dtp_rec_t recC
);

	typedef struct packed {
		dtp_pkg::dtp_rec_t [dtp_pkg::NUM_REC-1:0] recs;
	} dtp_store_state_t;

	dtp_store_state_t s;
	dtp_store_state_t n;

	always_comb begin
		n = s;
		if (wrEn && (wrIdx <= dtp_pkg::SERIAL_IDX)) begin
			n.recs[wrIdx] = wrRec; // R1 R2
		end
	end

	// Reset clears every record, so the feed-forward gain starts at zero.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s <= '0; // R14
		end else begin
			s <= n;
		end
	end

	assign recA = (rdIdxA <= dtp_pkg::SERIAL_IDX) ? s.recs[rdIdxA] : '0;
	assign recB = (rdIdxB <= dtp_pkg::SERIAL_IDX) ? s.recs[rdIdxB] : '0;
	assign recC = (rdIdxC <= dtp_pkg::SERIAL_IDX) ? s.recs[rdIdxC] : '0;

endmodule : dtp_record_store
`default_nettype wire

// ---- bench/dtp_ctrl_model.sv ----
// Model of the higher-order controller: destination select lines and start strobe.
// Assumes the caller runs go() from the clocked test sequence.
`timescale 1ns/10ps
`default_nettype none
module dtp_ctrl_model (
	// Clock
	input wire logic clk_sys,
	// Digital outputs to the positioner
	output logic [3:0] destinationSelect,
	output logic startStrobe
);
	initial begin
		destinationSelect = 4'h0;
		startStrobe = 1'b0;
	end
	// One clean rising edge per start; the select lines are inverted afterwards so a late sample is caught.
	task go(input logic [3:0] idx);
		@(posedge clk_sys);
		destinationSelect <= idx;
		startStrobe <= 1'b1;
		repeat (3) @(posedge clk_sys);
		startStrobe <= 1'b0;
		destinationSelect <= ~idx;
		repeat (2) @(posedge clk_sys);
	endtask : go
endmodule : dtp_ctrl_model
`default_nettype wire

// ---- bench/dtp_positioner_chk.sv ----
// Port-level assertions for the positioner.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module dtp_positioner_chk #(
	parameter int MS_CYCLES = 20
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// APB
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	// Motion
	input wire logic startStrobe,
	input wire logic signed [31:0] posSetpoint,
	input wire logic signed [16:0] velSetpoint,
	input wire logic moveActive,
	input wire logic destReached
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	logic ctlWr;
	logic signed [31:0] lastPosReg;
	logic [15:0] gapReg;
	assign ctlWr = psel && penable && pwrite && paddr == dtp_pkg::REG_CONTROL;
	// Cycles since the setpoint last changed; it may only move on profile ticks.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			lastPosReg <= '0;
			gapReg <= '0;
		end else begin
			lastPosReg <= posSetpoint;
			gapReg <= (posSetpoint != lastPosReg) ? 16'h0 : gapReg + 16'h1;
		end
	end
	sequence setup_s;
		psel && !penable;
	endsequence
	a_ready_high: assert property (pready) else $error("pready low");
	a_data_hold: assert property (!setup_s |=> $stable(prdata) && $stable(pslverr)) else $error("prdata moved");
	a_err_unmap: assert property (setup_s and paddr > 8'h38 |=> pslverr) else $error("no slave error");
	a_err_map: assert property (setup_s and paddr <= 8'h38 && paddr[1:0] == 2'b00 |=> !pslverr)
		else $error("spurious slave error");
	a_launch_clear: assert property ($rose(moveActive) |-> !destReached) else $error("reached at launch");
	a_reach_fall: assert property ($fell(destReached) && !$past(ctlWr) |-> moveActive)
		else $error("reached cleared without launch");
	a_idle_still: assert property (!moveActive && !destReached && !ctlWr |=> $stable(posSetpoint))
		else $error("idle setpoint moved");
	a_idle_vel: assert property (!moveActive && !destReached |-> velSetpoint == 17'sh0)
		else $error("idle speed not zero");
	a_tick_gap: assert property (posSetpoint != lastPosReg && !$past(ctlWr) |-> gapReg >= MS_CYCLES - 1)
		else $error("setpoint moved off tick");
endmodule : dtp_positioner_chk
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the positioner over APB and the digital inputs.
// Assumes a shortened profile tick of 20 clock cycles.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("FAIL %s exp %0h got %0h", n, e, g); end end
module tb;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hF;
	logic signed [31:0] actualPos = 32'sh64;
	wire pready, pslverr, startStrobe, moveActive, destReached;
	wire [31:0] prdata;
	wire [3:0] destinationSelect;
	wire signed [31:0] posSetpoint, feedForward;
	wire signed [16:0] velSetpoint;
	int miscompares = 0;
	int num_checks = 0;
	int cyc = 0;
	logic [31:0] rv;
	logic ev;
	always #50 clk_sys = ~clk_sys;
	dtp_positioner #(.MS_CYCLES(20)) uut (.clk_sys, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata,
		.pstrb, .pready, .prdata, .pslverr, .destinationSelect, .startStrobe, .actualPos, .posSetpoint,
		.velSetpoint, .feedForward, .moveActive, .destReached);
	dtp_ctrl_model m (.clk_sys, .destinationSelect, .startStrobe);
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rec(input logic [4:0] i, input logic [31:0] t, input logic [1:0] md, input logic [1:0] p);
		apb(dtp_pkg::REG_REC_SELECT, 1'b1, {27'h0, i});
		apb(dtp_pkg::REG_REC_TARGET, 1'b1, t);
		apb(dtp_pkg::REG_REC_SPEED, 1'b1, 32'h2);
		apb(dtp_pkg::REG_REC_ACCEL, 1'b1, 32'h2);
		apb(dtp_pkg::REG_REC_DECEL, 1'b1, 32'h2);
		apb(dtp_pkg::REG_REC_MODE, 1'b1, {26'h0, p, 2'b00, md});
	endtask : rec
	task reach;
		while (destReached !== 1'b1) @(posedge clk_sys);
	endtask : reach
	task t_store;
		rec(5'h10, 32'h37, 2'h2, 2'h0);
		pstrb <= 4'h1;
		apb(dtp_pkg::REG_REC_TARGET, 1'b1, 32'hFFFFFF2D);
		pstrb <= 4'hF;
		apb(dtp_pkg::REG_REC_SELECT, 1'b1, 32'h0);
		apb(dtp_pkg::REG_REC_TARGET, 1'b0, 32'h0);
		`CHK("table target", 32'h0, rv)
		apb(dtp_pkg::REG_REC_SELECT, 1'b1, 32'h10);
		apb(dtp_pkg::REG_REC_TARGET, 1'b0, 32'h0);
		`CHK("serial target", 32'h2D, rv)
		apb(8'h3C, 1'b0, 32'h0);
		`CHK("unmapped error", 1'b1, ev)
		$display("done store");
	endtask : t_store
	task t_abs;
		rec(5'h5, 32'h28, 2'h2, 2'h0);
		apb(dtp_pkg::REG_REC_FFGAIN, 1'b1, 32'h200);
		apb(dtp_pkg::REG_CONTROL, 1'b1, 32'h1);
		m.go(4'h5);
		`CHK("moving", 1'b1, moveActive)
		apb(dtp_pkg::REG_STATUS, 1'b0, 32'h0);
		`CHK("active index", 5'h5, rv[12:8])
		while (velSetpoint !== 17'sh2) @(posedge clk_sys);
		@(posedge clk_sys);
		`CHK("feed forward", 32'sh4, feedForward)
		reach();
		`CHK("abs position", 32'sh28, posSetpoint)
		`CHK("final speed", 17'sh0, velSetpoint)
		apb(dtp_pkg::REG_CONTROL, 1'b1, 32'h3);
		apb(dtp_pkg::REG_STATUS, 1'b0, 32'h0);
		`CHK("serial index", 5'h10, rv[12:8])
		reach();
		`CHK("serial position", 32'sh2D, posSetpoint)
		$display("done absolute");
	endtask : t_abs
	task t_rel;
		actualPos <= 32'sh50;
		rec(5'h3, 32'hA, 2'h0, 2'h0);
		rec(5'h2, 32'h7, 2'h1, 2'h0);
		m.go(4'h3);
		apb(dtp_pkg::REG_DEST_POS, 1'b0, 32'h0);
		`CHK("rel actual dest", 32'h5A, rv)
		reach();
		m.go(4'h2);
		apb(dtp_pkg::REG_DEST_POS, 1'b0, 32'h0);
		`CHK("rel last dest", 32'h61, rv)
		reach();
		`CHK("rel last pos", 32'sh61, posSetpoint)
		$display("done relative");
	endtask : t_rel
	task t_pol;
		for (int p = 0; p < 3; p++) begin
			rec(5'h7, 32'hC8, 2'h0, p[1:0]);
			rec(5'h8, -32'sd200, 2'h0, p[1:0]);
			m.go(4'h7);
			m.go(4'h8);
			apb(dtp_pkg::REG_STATUS, 1'b0, 32'h0);
			`CHK("policy index", (p == 1) ? 5'h8 : 5'h7, rv[12:8])
			`CHK("pending", p == 0, rv[1])
			if (p == 0) begin
				do apb(dtp_pkg::REG_STATUS, 1'b0, 32'h0); while (rv[12:8] !== 5'h8);
				`CHK("first move done", 32'sh118, posSetpoint)
			end
			apb(dtp_pkg::REG_CONTROL, 1'b1, 32'h0);
			// Re-home so the next pass starts a full move away from record 7's target.
			apb(dtp_pkg::REG_CONTROL, 1'b1, 32'h5);
		end
		$display("done policy");
	endtask : t_pol
	task conclude;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : conclude
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 90000) begin
			miscompares++;
			conclude();
		end
	end
	initial begin
		repeat (5) @(posedge clk_sys);
		resetn <= 1'b1;
		t_store();
		t_abs();
		t_rel();
		t_pol();
		conclude();
	end
endmodule : tb
bind dtp_positioner dtp_positioner_chk #(.MS_CYCLES(MS_CYCLES)) chk (.clk_sys, .resetn, .paddr, .psel,
	.penable, .pwrite, .pready, .prdata, .pslverr, .startStrobe, .posSetpoint, .velSetpoint, .moveActive,
	.destReached);
`default_nettype wire
